// file: logic/etdc_ctl_decode.sv
/*
 * etdc_ctl_decode.sv
 * Turns the control half of descriptor word 0 into the per-frame
 * control set handed to the MAC.
 * Assumes the caller latches the result only on a first segment.
 */
`timescale 1ns/1ps

module etdc_ctl_decode
   import etdc_pkg::*;
(
   // Descriptor word and global stamp switch
   input wire logic [31:0] desc0,
   input wire logic global_stamp_enable,
   // Decoded controls
   output etdc_frame_ctl_t frame_ctl
);

   logic [1:0] checksum_insert_ctrl;

   assign checksum_insert_ctrl = desc0[`ETDC_CSUM_HI:`ETDC_CSUM_LO];

   always_comb
   begin
      frame_ctl = '0;
      frame_ctl.ip_csum = checksum_insert_ctrl != `ETDC_CSUM_OFF;
      frame_ctl.payload_csum =
         checksum_insert_ctrl == `ETDC_CSUM_PAYLOAD ||
         checksum_insert_ctrl == `ETDC_CSUM_FULL;
      frame_ctl.pseudo_csum =
         checksum_insert_ctrl == `ETDC_CSUM_FULL;
      frame_ctl.stamp = desc0[`ETDC_STAMP_REQ] & global_stamp_enable;
      frame_ctl.pad = ~desc0[`ETDC_PAD_DIS];
      frame_ctl.crc = ~desc0[`ETDC_CRC_DIS];
   end

endmodule // etdc_ctl_decode

// file: logic/etdc_pkg.sv
/*
 * etdc_pkg.sv
 * Types of the transmit descriptor control block: state codes, the
 * per-frame control set, the segment command and the MAC status.
 * Assumes etdc_regs.svh is on the include path.
 */
`include "etdc_regs.svh"

package etdc_pkg;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_CHECK = 5'h02,
      ST_ISSUE = 5'h04,
      ST_WAIT = 5'h08,
      ST_SUSP = 5'h10
   } etdc_state_t;

   typedef struct packed {
      logic ip_csum;
      logic payload_csum;
      logic pseudo_csum;
      logic stamp;
      logic pad;
      logic crc;
   } etdc_frame_ctl_t;

   typedef struct packed {
      logic first;
      logic last;
      logic [31:0] addr1;
      logic [`ETDC_LEN_W-1:0] len1;
      logic [31:0] addr2;
      logic [`ETDC_LEN_W-1:0] len2;
      etdc_frame_ctl_t ctl;
      logic [`ETDC_PAD_W-1:0] pad_bytes;
   } etdc_seg_cmd_t;

   typedef struct packed {
      logic frame_done;
      logic stamp_valid;
      logic [63:0] stamp;
   } etdc_mac_sts_t;

   typedef struct packed {
      etdc_state_t st;
      logic [31:0] desc0;
      logic [`ETDC_LEN_W-1:0] len1;
      logic [`ETDC_LEN_W-1:0] len2;
      logic [31:0] buf1;
      logic [31:0] addr2;
      logic [1:0] ctrl;
      logic [`ETDC_STS_W-1:0] sts;
      logic [`ETDC_STS_W-1:0] mask;
      logic [31:0] prdata;
      logic in_frame;
      etdc_frame_ctl_t fctl;
      logic [15:0] frame_len;
      logic [63:0] stamp;
      logic cmd_valid;
      etdc_seg_cmd_t cmd;
   } etdc_core_t;

endpackage

// file: logic/etdc_regs.svh
/*
 * etdc_regs.svh
 * Register offsets, descriptor field positions, reset values and frame
 * size constants of the transmit descriptor control block.
 * Assumes a 32-bit APB with byte addresses and one aligned word per
 * register.
 */
`ifndef ETDC_REGS_SVH
`define ETDC_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ETDC_OFS_DESC0 8'h00
`define ETDC_OFS_DESC1 8'h04
`define ETDC_OFS_BUF1 8'h08
`define ETDC_OFS_ADDR2 8'h0c
`define ETDC_OFS_CTRL 8'h10
`define ETDC_OFS_STATUS 8'h14
`define ETDC_OFS_MASK 8'h18
`define ETDC_OFS_STATE 8'h1c
`define ETDC_OFS_STAMP_LO 8'h20
`define ETDC_OFS_STAMP_HI 8'h24

// ****************************************************************
// Descriptor word 0 control fields
// ****************************************************************
`define ETDC_CHAIN 20
`define ETDC_CSUM_LO 22
`define ETDC_CSUM_HI 23
`define ETDC_STAMP_REQ 25
`define ETDC_PAD_DIS 26
`define ETDC_CRC_DIS 27
`define ETDC_FIRST 28
`define ETDC_LAST 29
`define ETDC_IRQ_REQ 30
`define ETDC_OWN 31
`define ETDC_DESC0_MASK 32'hfed0_0000
`define ETDC_CSUM_OFF 2'h0
`define ETDC_CSUM_IP 2'h1
`define ETDC_CSUM_PAYLOAD 2'h2
`define ETDC_CSUM_FULL 2'h3

// ****************************************************************
// Descriptor word 1, control and status fields
// ****************************************************************
`define ETDC_LEN_W 13
`define ETDC_LEN1_LO 0
`define ETDC_LEN2_LO 16
`define ETDC_CTRL_ENABLE 0
`define ETDC_CTRL_STAMP_EN 1
`define ETDC_STS_W 4
`define ETDC_STS_DONE 0
`define ETDC_STS_SUSP 1
`define ETDC_STS_STAMP 2
`define ETDC_STS_SEGERR 3

// ****************************************************************
// Reset values and frame sizes
// ****************************************************************
`define ETDC_RST_DESC0 32'h0000_0000
`define ETDC_RST_CTRL 2'h0
`define ETDC_RST_MASK 4'h0
`define ETDC_MIN_FRAME 16'h0040
`define ETDC_CRC_LEN 16'h0004
`define ETDC_PAD_W 6

`endif

// file: logic/etdc_top.sv
/*
 * etdc_top.sv
 * Transmit descriptor control: holds one descriptor written over APB,
 * decodes its control bits, issues segment commands to the MAC and
 * hands the descriptor back when done.
 * Assumes the MAC pulses frame_done once per frame after the last
 * segment command, with the stamp valid in that same cycle.
 */
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps

// Behaviour
// - Code 00 no checksum, 01 IP header
// - Code 10 adds payload, no pseudo header
// - Code 11 adds hardware pseudo header checksum
// - Stamp when request and global enable, first
// - Pad on forces pad and CRC short frames
// - Pad off sends short frames unpadded
// - CRC disable drops CRC, first segment only
// - First flag starts a new frame
// - Last flag ends the frame
// - Completion request raises done interrupt
// - Owner bit: zero CPU, one DMA
// - DMA clears owner after buffer or frame
// - Chain flag makes address two a pointer
module etdc_top
   import etdc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Segment commands to the MAC
   output logic seg_valid,
   input wire logic seg_ready,
   output etdc_seg_cmd_t seg_cmd,
   // Frame status from the MAC
   input wire etdc_mac_sts_t mac_sts,
   // Next descriptor pointer
   output logic [31:0] next_desc_ptr,
   output logic next_desc_valid,
   // Interrupt
   output logic irq
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   etdc_core_t r;
   etdc_core_t next_r;
   etdc_frame_ctl_t dec_ctl;
   logic wr_access;
   logic rd_setup;
   logic mapped;
   logic [31:0] rd_word;
   logic own;
   logic first;
   logic last;
   logic chained;
   logic [13:0] seg_bytes;
   logic [15:0] total_len;
   logic [15:0] min_body;
   logic short_frame;
   logic [`ETDC_STS_W-1:0] sts_event;
   logic [`ETDC_STS_W-1:0] sts_clear;

   etdc_ctl_decode u_decode (
      .desc0(r.desc0),
      .global_stamp_enable(r.ctrl[`ETDC_CTRL_STAMP_EN]),
      .frame_ctl(dec_ctl)
   );

   // ****************************************************************
   // Descriptor view
   // ****************************************************************
   assign own = r.desc0[`ETDC_OWN];
   assign first = r.desc0[`ETDC_FIRST];
   assign last = r.desc0[`ETDC_LAST];
   assign chained = r.desc0[`ETDC_CHAIN];
   // A chained descriptor carries no second buffer
   assign seg_bytes = {1'b0, r.len1} +
      (chained ? 14'h0000 : {1'b0, r.len2});
   assign total_len = first ? {2'h0, seg_bytes} :
      r.frame_len + {2'h0, seg_bytes};
   assign min_body = `ETDC_MIN_FRAME - `ETDC_CRC_LEN;
   assign short_frame = total_len < min_body;

   // ****************************************************************
   // APB slave
   // ****************************************************************
   // Read data is caught in the setup phase so pready never waits
   assign wr_access = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = r.prdata;

   always_comb
   begin
      mapped = 1'b1;
      rd_word = 32'h0000_0000;
      case (paddr)
         `ETDC_OFS_DESC0: rd_word = r.desc0;
         `ETDC_OFS_DESC1: rd_word = {3'h0, r.len2, 3'h0, r.len1};
         `ETDC_OFS_BUF1: rd_word = r.buf1;
         `ETDC_OFS_ADDR2: rd_word = r.addr2;
         `ETDC_OFS_CTRL: rd_word = 32'(r.ctrl);
         `ETDC_OFS_STATUS: rd_word = 32'(r.sts);
         `ETDC_OFS_MASK: rd_word = 32'(r.mask);
         `ETDC_OFS_STATE:
            rd_word = {r.frame_len, 7'h00, r.in_frame, 3'h0, r.st};
         `ETDC_OFS_STAMP_LO: rd_word = r.stamp[31:0];
         `ETDC_OFS_STAMP_HI: rd_word = r.stamp[63:32];
         default: mapped = 1'b0;
      endcase
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign seg_valid = r.cmd_valid;
   assign seg_cmd = r.cmd;
   assign irq = |(r.sts & r.mask);
   assign next_desc_ptr = r.addr2;
   assign next_desc_valid = chained & own;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      next_r = r;
      sts_event = '0;
      sts_clear = '0;
      if (rd_setup)
         next_r.prdata = rd_word;
      if (wr_access)
      begin
         case (paddr)
            // The descriptor is locked while the DMA owns it
            `ETDC_OFS_DESC0:
               if (!own)
                  next_r.desc0 = pwdata & `ETDC_DESC0_MASK;
            `ETDC_OFS_DESC1:
               if (!own)
               begin
                  next_r.len1 = pwdata[`ETDC_LEN1_LO+:`ETDC_LEN_W];
                  next_r.len2 = pwdata[`ETDC_LEN2_LO+:`ETDC_LEN_W];
               end
            `ETDC_OFS_BUF1:
               if (!own)
                  next_r.buf1 = pwdata;
            `ETDC_OFS_ADDR2:
               if (!own)
                  next_r.addr2 = pwdata;
            `ETDC_OFS_CTRL: next_r.ctrl = pwdata[1:0];
            `ETDC_OFS_STATUS: sts_clear = pwdata[`ETDC_STS_W-1:0];
            `ETDC_OFS_MASK: next_r.mask = pwdata[`ETDC_STS_W-1:0];
            default: ;
         endcase
      end
      case (r.st)
         ST_IDLE:
            if (r.ctrl[`ETDC_CTRL_ENABLE])
               next_r.st = ST_CHECK;
         ST_CHECK:
            if (!r.ctrl[`ETDC_CTRL_ENABLE])
               next_r.st = ST_IDLE;
            else if (!own)
            begin
               sts_event[`ETDC_STS_SUSP] = 1'b1;
               next_r.st = ST_SUSP;
            end
            else if (!r.in_frame && !first)
            begin
               // A segment without the first flag and with no frame open is handed back
               sts_event[`ETDC_STS_SEGERR] = 1'b1;
               next_r.desc0[`ETDC_OWN] = 1'b0;
            end
            else
            begin
               if (first)
               begin
                  next_r.fctl = dec_ctl;
                  next_r.in_frame = 1'b1;
               end
               next_r.frame_len = total_len;
               next_r.cmd.first = first;
               next_r.cmd.last = last;
               next_r.cmd.addr1 = r.buf1;
               next_r.cmd.len1 = r.len1;
               next_r.cmd.addr2 = chained ? 32'h0000_0000 : r.addr2;
               next_r.cmd.len2 = chained ? '0 : r.len2;
               next_r.cmd.ctl = first ? dec_ctl : r.fctl;
               next_r.cmd.pad_bytes = '0;
               if (last && next_r.cmd.ctl.pad && short_frame)
               begin
                  next_r.cmd.pad_bytes =
                     `ETDC_PAD_W'(min_body - total_len);
                  next_r.cmd.ctl.crc = 1'b1;
               end
               next_r.cmd_valid = 1'b1;
               next_r.st = ST_ISSUE;
            end
         ST_ISSUE:
            if (seg_ready)
            begin
               next_r.cmd_valid = 1'b0;
               if (r.cmd.last)
                  next_r.st = ST_WAIT;
               else
               begin
                  next_r.desc0[`ETDC_OWN] = 1'b0;
                  next_r.st = ST_CHECK;
               end
            end
         ST_WAIT:
            if (mac_sts.frame_done)
            begin
               next_r.desc0[`ETDC_OWN] = 1'b0;
               next_r.in_frame = 1'b0;
               if (r.desc0[`ETDC_IRQ_REQ])
                  sts_event[`ETDC_STS_DONE] = 1'b1;
               if (r.fctl.stamp && mac_sts.stamp_valid)
               begin
                  next_r.stamp = mac_sts.stamp;
                  sts_event[`ETDC_STS_STAMP] = 1'b1;
               end
               next_r.st = ST_CHECK;
            end
         ST_SUSP:
            if (own)
               next_r.st = ST_CHECK;
            else if (!r.ctrl[`ETDC_CTRL_ENABLE])
               next_r.st = ST_IDLE;
         default: next_r.st = ST_IDLE;
      endcase
      // A new event beats a clear written in the same cycle
      next_r.sts = (r.sts & ~sts_clear) | sts_event;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r <= '0;
         r.st <= ST_IDLE;
         r.desc0 <= `ETDC_RST_DESC0;
         r.ctrl <= `ETDC_RST_CTRL;
         r.mask <= `ETDC_RST_MASK;
      end
      else
         r <= next_r;
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   csum_ip_a: assert property (
      seg_valid && seg_cmd.first |->
      seg_cmd.ctl.ip_csum ==
      (r.desc0[`ETDC_CSUM_HI:`ETDC_CSUM_LO] != `ETDC_CSUM_OFF))
      else $error("IP checksum select differs from descriptor");

   csum_payload_a: assert property (
      seg_valid && seg_cmd.first && r.desc0[`ETDC_CSUM_HI] |->
      seg_cmd.ctl.payload_csum && seg_cmd.ctl.ip_csum)
      else $error("Payload checksum not selected");

   csum_pseudo_a: assert property (
      seg_valid && seg_cmd.first |->
      seg_cmd.ctl.pseudo_csum ==
      (r.desc0[`ETDC_CSUM_HI:`ETDC_CSUM_LO] == `ETDC_CSUM_FULL))
      else $error("Pseudo header select wrong");

   stamp_req_a: assert property (
      seg_valid && seg_cmd.first |-> seg_cmd.ctl.stamp ==
      (r.desc0[`ETDC_STAMP_REQ] && r.ctrl[`ETDC_CTRL_STAMP_EN]))
      else $error("Stamp request decoded wrong");

   pad_short_a: assert property (
      $rose(seg_valid) && seg_cmd.last && seg_cmd.ctl.pad &&
      r.frame_len < min_body |->
      seg_cmd.ctl.crc &&
      16'(seg_cmd.pad_bytes) + r.frame_len == min_body)
      else $error("Short frame not padded to minimum");

   no_pad_a: assert property (
      seg_valid && !seg_cmd.ctl.pad |-> seg_cmd.pad_bytes == '0)
      else $error("Padding with pad disabled");

   cmd_hold_a: assert property (
      seg_valid && !seg_ready |=> seg_valid && $stable(seg_cmd))
      else $error("Segment command dropped before ready");

   own_return_a: assert property (
      r.st == ST_WAIT && mac_sts.frame_done |=>
      !own ##1 !seg_valid)
      else $error("Descriptor not returned after frame");

   done_irq_a: assert property (
      r.st == ST_WAIT && mac_sts.frame_done &&
      r.desc0[`ETDC_IRQ_REQ] && r.mask[`ETDC_STS_DONE] |=>
      r.sts[`ETDC_STS_DONE] && irq)
      else $error("Completion interrupt missing");

   chain_a: assert property (
      seg_valid && r.desc0[`ETDC_CHAIN] |->
      seg_cmd.len2 == '0 && next_desc_valid)
      else $error("Chained descriptor used second buffer");

   susp_hold_a: assert property (
      r.st == ST_SUSP && !own |=> !seg_valid)
      else $error("Segment issued from CPU-owned descriptor");

endmodule // etdc_top

// file: tb/etdc_mac_model.sv
/*
 * MAC stand-in on the segment link: accepts commands after a chosen
 * delay and ends a frame six cycles after its last segment.
 * Assumes the engine holds seg_cmd steady while seg_valid is high.
 */
`timescale 1ns/1ps

module etdc_mac_model
   import etdc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Segment link
   input wire logic seg_valid,
   input wire etdc_seg_cmd_t seg_cmd,
   output logic seg_ready,
   output etdc_mac_sts_t mac_sts,
   // Bench control and capture
   input wire logic [1:0] delay,
   output etdc_seg_cmd_t got_cmd,
   output logic [7:0] got_count,
   output logic [63:0] got_stamp
);
   logic [1:0] wait_cnt;
   logic [3:0] done_cnt;
   logic [63:0] stamp_nx;
   logic stall;

   // Stamp lines move every cycle, so a stale capture cannot match
   assign stamp_nx = {mac_sts.stamp[62:0], ~mac_sts.stamp[63]};
   assign stall = seg_valid && !seg_ready && wait_cnt != delay;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         seg_ready <= 1'b0;
         mac_sts <= '0;
         got_cmd <= '0;
         got_count <= 8'h00;
         got_stamp <= 64'h0;
         wait_cnt <= 2'h0;
         done_cnt <= 4'h0;
      end
      else
      begin
         seg_ready <= seg_valid && !seg_ready && wait_cnt == delay;
         wait_cnt <= stall ? wait_cnt + 2'h1 : 2'h0;
         mac_sts.stamp <= stamp_nx;
         mac_sts.frame_done <= done_cnt == 4'h1;
         mac_sts.stamp_valid <= done_cnt == 4'h1;
         if (done_cnt == 4'h1)
            got_stamp <= stamp_nx;
         if (done_cnt != 4'h0)
            done_cnt <= done_cnt - 4'h1;
         if (seg_valid && seg_ready)
         begin
            got_cmd <= seg_cmd;
            got_count <= got_count + 8'h01;
            if (seg_cmd.last)
               done_cnt <= 4'h6;
         end
      end
   end
endmodule // etdc_mac_model

// file: tb/test_eth_tx_descriptor_control.sv
/*
 * Self-checking bench for etdc_top: APB master tasks, a MAC model on
 * the segment link, hand-picked and random descriptors.
 * Assumes etdc_regs.svh and etdc_pkg are compiled first.
 */
`timescale 1ns/1ps
`include "etdc_regs.svh"

module test_eth_tx_descriptor_control;
   import etdc_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr, seg_valid, seg_ready, irq;
   logic [7:0] paddr = 8'h00, got_count;
   logic [31:0] pwdata = 32'h0, prdata, next_desc_ptr, rd, seed = 32'd89;
   logic next_desc_valid, slverr, open_frame = 1'b0, gstamp = 1'b0;
   logic [1:0] delay = 2'h0;
   logic [63:0] got_stamp;
   etdc_seg_cmd_t seg_cmd, got_cmd;
   etdc_mac_sts_t mac_sts;
   etdc_frame_ctl_t fctl;
   int err_count = 0, compares = 0, total;

   always #5 pclk = ~pclk;

   etdc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .seg_valid(seg_valid), .seg_ready(seg_ready), .seg_cmd(seg_cmd),
      .mac_sts(mac_sts), .next_desc_ptr(next_desc_ptr),
      .next_desc_valid(next_desc_valid), .irq(irq));
   etdc_mac_model mac (.pclk(pclk), .presetn(presetn),
      .seg_valid(seg_valid), .seg_cmd(seg_cmd), .seg_ready(seg_ready),
      .mac_sts(mac_sts), .delay(delay), .got_cmd(got_cmd),
      .got_count(got_count), .got_stamp(got_stamp));

   // **********
   // Helpers
   // **********
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic report_and_stop();
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(string w, logic [63:0] e, logic [63:0] g);
      compares++;
      if (g !== e)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", w, e, g);
      end
   endtask

   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
         err_count++;
         report_and_stop();
      end
   endtask

   // **********
   // One descriptor, handed over and checked on return
   // **********
   task automatic seg(logic [1:0] cs, logic req, pdis, cdis, first, last,
                      completion_irq_request, chain, logic [12:0] l1, l2);
      logic [31:0] a1, a2;
      logic [7:0] cnt;
      logic [3:0] es;
      logic ok;
      logic [63:0] ed;
      int n, pad;
      a1 = rnd();
      a2 = rnd();
      cnt = got_count;
      ok = first || open_frame;
      apb(1'b1, `ETDC_OFS_DESC1, {3'h0, l2, 3'h0, l1});
      apb(1'b1, `ETDC_OFS_BUF1, a1);
      apb(1'b1, `ETDC_OFS_ADDR2, a2);
      apb(1'b1, `ETDC_OFS_DESC0, {1'b1, completion_irq_request, last, first, cdis, pdis,
          req, 1'b0, cs, 1'b0, chain, 20'h0});
      #1;
      check("chain valid", 64'(chain), 64'(next_desc_valid));
      if (chain)
         check("chain ptr", 64'(a2), 64'(next_desc_ptr));
      if (last)
         apb(1'b1, `ETDC_OFS_DESC1, 32'h0);
      n = 0;
      do
      begin
         apb(1'b0, `ETDC_OFS_DESC0, 32'h0);
         n++;
      end
      while (rd[`ETDC_OWN] !== 1'b0 && n < 40);
      check("owner back", 64'h0, 64'(rd[`ETDC_OWN]));
      if (rd[`ETDC_OWN] !== 1'b0)
         report_and_stop();
      if (last)
      begin
         apb(1'b0, `ETDC_OFS_DESC1, 32'h0);
         // A refused descriptor is back with the CPU, so the write lands
         ed = ok ? {35'h0, l2, 3'h0, l1} : 64'h0;
         check("held desc1", ed, 64'(rd));
      end
      if (first)
      begin
         fctl = '{cs != 2'h0, cs[1], cs == 2'h3, req & gstamp, !pdis, !cdis};
         total = 0;
      end
      if (ok)
      begin
         total += 32'(l1) + (chain ? 0 : 32'(l2));
         pad = (last && fctl.pad && total < 60) ? 60 - total : 0;
         check("count", 64'(cnt + 8'h01), 64'(got_count));
         check("first", 64'(first), 64'(got_cmd.first));
         check("last", 64'(last), 64'(got_cmd.last));
         check("addr1", 64'(a1), 64'(got_cmd.addr1));
         check("len1", 64'(l1), 64'(got_cmd.len1));
         check("addr2", chain ? 64'h0 : 64'(a2), 64'(got_cmd.addr2));
         check("len2", chain ? 64'h0 : 64'(l2), 64'(got_cmd.len2));
         check("ctl", 64'({fctl[5:1], fctl.crc | (pad > 0)}),
               64'(got_cmd.ctl));
         check("pad", 64'(pad), 64'(got_cmd.pad_bytes));
         open_frame = !last;
      end
      else
         check("refused count", 64'(cnt), 64'(got_count));
      es = {!ok, ok & last & fctl.stamp, 1'b0, ok & last & completion_irq_request};
      apb(1'b0, `ETDC_OFS_STATUS, 32'h0);
      check("status", 64'(es), 64'(rd[3:0] & 4'hd));
      check("irq", 64'(es[0]), 64'(irq));
      if (es[2])
      begin
         apb(1'b0, `ETDC_OFS_STAMP_LO, 32'h0);
         check("stamp lo", 64'(got_stamp[31:0]), 64'(rd));
         apb(1'b0, `ETDC_OFS_STAMP_HI, 32'h0);
         check("stamp hi", 64'(got_stamp[63:32]), 64'(rd));
      end
      apb(1'b1, `ETDC_OFS_STATUS, 32'hf);
      #1;
      check("irq cleared", 64'h0, 64'(irq));
   endtask

   // **********
   // Main sequence
   // **********
   initial
   begin
      logic [31:0] r;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b0, 8'(i * 4 + (i > 0 ? 12 : 0)), 32'h0);
         check("reset value", 64'h0, 64'(rd));
      end
      apb(1'b1, 8'h40, 32'hffff_ffff);
      apb(1'b0, 8'h40, 32'h0);
      check("unmapped err", 64'h1, 64'(slverr));
      check("unmapped data", 64'h0, 64'(rd));
      apb(1'b1, `ETDC_OFS_CTRL, 32'h1);
      apb(1'b1, `ETDC_OFS_MASK, 32'h0);
      #1;
      check("irq masked", 64'h0, 64'(irq));
      apb(1'b1, `ETDC_OFS_MASK, 32'h2);
      #1;
      check("irq suspend", 64'h1, 64'(irq));
      apb(1'b0, `ETDC_OFS_STATUS, 32'h0);
      check("suspended", 64'h1, 64'(rd[`ETDC_STS_SUSP]));
      check("no command", 64'h0, 64'(got_count));
      apb(1'b1, `ETDC_OFS_MASK, 32'h1);
      seg(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 13'd5, 13'd0);
      gstamp = 1'b1;
      apb(1'b1, `ETDC_OFS_CTRL, 32'h3);
      seg(2'h3, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 13'd30, 13'd29);
      seg(2'h2, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 13'd60, 13'd5);
      delay <= 2'h3;
      seg(2'h1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 13'd10, 13'd0);
      seg(2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 13'd5, 13'd0);
      for (int k = 0; k < 14; k++)
      begin
         r = rnd();
         gstamp = r[0];
         delay <= r[2:1];
         apb(1'b1, `ETDC_OFS_CTRL, {30'h0, r[0], 1'b1});
         if (r[3])
            seg(r[5:4], r[6], r[7], r[20], 1'b1, 1'b0, r[21], r[22],
                {7'h0, r[13:8]} | 13'h1, {7'h0, r[19:14]});
         seg(r[5:4], r[6], r[7], r[20], !r[3], 1'b1, r[23], r[24],
             {8'h0, r[29:25]} | 13'h1, {8'h0, r[31:27]});
      end
      report_and_stop();
   end
endmodule // test_eth_tx_descriptor_control
